// >>> include/flash_ctrl_pkg.sv
// Shared constants and types for the flash self-programming sequencer
package flash_ctrl_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int DATA_W = 14;
   localparam int ADDR_W = 15;
   localparam int ROW_W = 10;
   localparam int LAT_IDX_W = 5;
   localparam int LATCH_WORDS = 32;
   localparam int OFS_W = 8;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_DATA_LOW = 8'h00;
   localparam logic [7:0] OFS_DATA_HIGH = 8'h04;
   localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
   localparam logic [7:0] OFS_ADDR_HIGH = 8'h0C;
   localparam logic [7:0] OFS_CONTROL = 8'h10;
   localparam logic [7:0] OFS_UNLOCK = 8'h14;

   // ----------------------------------------
   // Control register bit positions
   // ----------------------------------------
   localparam int CTL_FIXED_ONE = 7;
   localparam int CTL_CFG_SEL = 6;
   localparam int CTL_LATCH_ONLY = 5;
   localparam int CTL_ERASE_SEL = 4;
   localparam int CTL_ERR = 3;
   localparam int CTL_PROG_EN = 2;
   localparam int CTL_WR = 1;
   localparam int CTL_RD = 0;

   // ----------------------------------------
   // Fixed values and reset values
   // ----------------------------------------
   localparam logic [7:0] UNLOCK_KEY_1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY_2 = 8'hAA;
   localparam logic [DATA_W-1:0] LATCH_BLANK = 14'h3FFF;
   localparam logic [7:0] UNUSED_READ = 8'h00;
   localparam logic [7:0] ADDR_LOW_RESET = 8'h00;
   localparam logic [6:0] ADDR_HIGH_RESET = 7'h00;
   localparam logic [7:0] DATA_LOW_RESET = 8'h00;
   localparam logic [5:0] DATA_HIGH_RESET = 6'h00;

   // Configuration space: bit 15 of the location is implied by the select bit
   localparam logic [ADDR_W-1:0] CFG_UID_FIRST = 15'h0000;
   localparam logic [ADDR_W-1:0] CFG_UID_LAST = 15'h0003;
   localparam logic [ADDR_W-1:0] CFG_DEVID = 15'h0006;
   localparam logic [ADDR_W-1:0] CFG_WORD_FIRST = 15'h0007;
   localparam logic [ADDR_W-1:0] CFG_WORD_LAST = 15'h0008;

   // ----------------------------------------
   // State encodings
   // ----------------------------------------
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b000,
      SEQ_LATCH = 3'b001,
      SEQ_PROG = 3'b010,
      SEQ_ERASE = 3'b011,
      SEQ_READ = 3'b100,
      SEQ_RDCAP = 3'b101
   } seq_type;

   typedef enum logic [1:0] {
      UNL_IDLE = 2'b00,
      UNL_KEY1 = 2'b01,
      UNL_ARMED = 2'b10
   } unlock_type;

endpackage

// >>> design/write_latch_row.sv
// Row of program-memory write latches, blanked after every program or erase
`timescale 1ns/1ps
module write_latch_row import flash_ctrl_pkg::*; #(
   parameter int WORDS = LATCH_WORDS,
   parameter int WIDTH = DATA_W,
   parameter int IDX_W = LAT_IDX_W
) (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, active low
   input wire logic load, // Load one latch
   input wire logic [IDX_W-1:0] load_idx, // Latch index within the row
   input wire logic [WIDTH-1:0] load_data, // Word to load
   input wire logic blank, // Return all latches to blank
   output logic [WORDS*WIDTH-1:0] row_data // All latch contents
);

   typedef struct packed {
      logic [WORDS-1:0][WIDTH-1:0] lat;
   } latch_state_type;

   latch_state_type s_r;
   latch_state_type s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (blank) begin
         s_nxt.lat = {WORDS{WIDTH'(LATCH_BLANK)}};
      end else if (load) begin
         s_nxt.lat[load_idx] = load_data;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r.lat <= {WORDS{WIDTH'(LATCH_BLANK)}};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign row_data = s_r.lat;

endmodule // write_latch_row

// >>> design/self_program_flash_control.sv
// Flash self-programming sequencer with AHB-Lite register slave
//
// Operation
// - Select bit one steers access to configuration space, zero to program flash.
// - Config user IDs read/write; device ID and config words read only.
// - Config read outside allowed locations clears both data registers to zero.
// - Data word 14 bits; high data bits seven and six read zero.
// - Address 15 bits; high address bit seven reads as one.
// - Latch-only write command loads the addressed latch and never programs.
// - Otherwise a write loads the latch then programs all latches at once.
// - Erase-select makes the command erase; hardware clears it on completion.
// - Latch-only bit is ignored during an erase.
// - Every write-start attempt made while no sequence runs sets error flag; normal completion clears it.
// - Program/erase enable zero inhibits all program and erase cycles.
// - Write-start launches self-timed operation; set only, hardware clears it.
// - Read-start performs one-cycle flash read; set only, hardware clears it.
// - Control register bit seven always reads one.
// - Row of 32 latches; upper ten address bits row, lower five latch.
// - All latches return to blank after every program or erase; a latch-only write leaves them loaded.
// - Interrupted unlock sequence neither loads a latch nor starts programming.
// - Programming never erases automatically.
`timescale 1ns/1ps
module self_program_flash_control import flash_ctrl_pkg::*; #(
   parameter logic [DATA_W-1:0] DEVICE_REV_ID = 14'h1234 // Arbitrary identity value
) (
   input wire logic hclk, // System clock, 100 MHz
   input wire logic hresetn, // Async reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic hreadyout, // Slave ready
   output logic hresp, // Always OKAY
   output logic [31:0] hrdata, // Read data
   output logic [ADDR_W-1:0] flash_addr, // Flash word address
   output logic flash_cfg_sel, // Configuration space select
   output logic flash_rd_en, // One-cycle read strobe
   input wire logic [DATA_W-1:0] flash_rd_data, // Read word, valid cycle after strobe
   output logic flash_prog_req, // Program row request, held until done
   output logic flash_erase_req, // Erase row request, held until done
   output logic [ROW_W-1:0] flash_row, // Row being programmed or erased
   output logic [LATCH_WORDS*DATA_W-1:0] flash_row_data, // Latch contents to program
   input wire logic flash_op_done, // Program or erase finished, one-cycle pulse
   output logic cpu_stall // Holds the processor during a write
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] dat_lo;
      logic [5:0] dat_hi;
      logic [7:0] adr_lo;
      logic [6:0] adr_hi;
      logic cfg_sel;
      logic latch_only;
      logic erase_sel;
      logic err;
      logic prog_en;
      logic wr;
      logic rd;
      unlock_type unl;
      seq_type seq;
      logic ph_valid;
      logic ph_write;
      logic [OFS_W-1:0] ph_addr;
      logic [31:0] hrdata;
   } state_type;

   state_type s_r;
   state_type s_nxt;
   logic latch_load;
   logic latch_blank;
   logic [7:0] wbyte;
   logic [ADDR_W-1:0] cur_addr;

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   function automatic logic cfg_writable(input logic [ADDR_W-1:0] a);
      return (a >= CFG_UID_FIRST) && (a <= CFG_UID_LAST);
   endfunction

   function automatic logic cfg_from_array(input logic [ADDR_W-1:0] a);
      return cfg_writable(a) || ((a >= CFG_WORD_FIRST) && (a <= CFG_WORD_LAST));
   endfunction

   function automatic logic [7:0] reg_read(input logic [OFS_W-1:0] ofs, input state_type st);
      logic [7:0] v;
      v = UNUSED_READ;
      case (ofs)
         OFS_DATA_LOW: v = st.dat_lo;
         OFS_DATA_HIGH: v = {2'b00, st.dat_hi};
         OFS_ADDR_LOW: v = st.adr_lo;
         OFS_ADDR_HIGH: v = {1'b1, st.adr_hi};
         OFS_CONTROL: v = {1'b1, st.cfg_sel, st.latch_only, st.erase_sel, st.err, st.prog_en, st.wr, st.rd};
         default: v = UNUSED_READ;
      endcase
      return v;
   endfunction

   assign wbyte = hwdata[7:0];
   assign cur_addr = {s_r.adr_hi, s_r.adr_lo};

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;

      // Sequencer
      unique case (s_r.seq)
         SEQ_IDLE: begin
         end
         SEQ_LATCH: begin
            if (s_r.latch_only) begin
               s_nxt.wr = 1'b0;
               s_nxt.err = 1'b0;
               s_nxt.seq = SEQ_IDLE;
            end else begin
               s_nxt.seq = SEQ_PROG;
            end
         end
         SEQ_PROG, SEQ_ERASE: begin
            if (flash_op_done) begin
               s_nxt.wr = 1'b0;
               s_nxt.err = 1'b0;
               s_nxt.erase_sel = 1'b0;
               s_nxt.seq = SEQ_IDLE;
            end
         end
         SEQ_READ: begin
            s_nxt.seq = SEQ_RDCAP;
         end
         SEQ_RDCAP: begin
            if (!s_r.cfg_sel || cfg_from_array(cur_addr)) begin
               {s_nxt.dat_hi, s_nxt.dat_lo} = flash_rd_data;
            end else if (cur_addr == CFG_DEVID) begin
               {s_nxt.dat_hi, s_nxt.dat_lo} = DEVICE_REV_ID;
            end else begin
               {s_nxt.dat_hi, s_nxt.dat_lo} = '0;
            end
            s_nxt.rd = 1'b0;
            s_nxt.seq = SEQ_IDLE;
         end
         default: begin
            s_nxt.seq = SEQ_IDLE;
         end
      endcase

      // Bus write data phase; ignored while any sequence runs, including a read sequence, during which the processor is not held
      if (s_r.ph_valid && s_r.ph_write && (s_r.seq == SEQ_IDLE)) begin
         if (s_r.ph_addr != OFS_UNLOCK) begin
            s_nxt.unl = UNL_IDLE;
         end
         case (s_r.ph_addr)
            OFS_DATA_LOW: s_nxt.dat_lo = wbyte;
            OFS_DATA_HIGH: s_nxt.dat_hi = wbyte[5:0];
            OFS_ADDR_LOW: s_nxt.adr_lo = wbyte;
            OFS_ADDR_HIGH: s_nxt.adr_hi = wbyte[6:0];
            OFS_CONTROL: begin
               s_nxt.cfg_sel = wbyte[CTL_CFG_SEL];
               s_nxt.latch_only = wbyte[CTL_LATCH_ONLY];
               s_nxt.erase_sel = wbyte[CTL_ERASE_SEL];
               s_nxt.err = wbyte[CTL_ERR];
               s_nxt.prog_en = wbyte[CTL_PROG_EN];
               if (wbyte[CTL_WR]) begin
                  s_nxt.err = 1'b1;
                  if ((s_r.unl == UNL_ARMED) && wbyte[CTL_PROG_EN]
                      && (!wbyte[CTL_CFG_SEL] || cfg_writable(cur_addr))) begin
                     s_nxt.wr = 1'b1;
                     s_nxt.seq = wbyte[CTL_ERASE_SEL] ? SEQ_ERASE : SEQ_LATCH;
                  end
               end else if (wbyte[CTL_RD]) begin
                  s_nxt.rd = 1'b1;
                  s_nxt.seq = SEQ_READ;
               end
            end
            OFS_UNLOCK: begin
               if (wbyte == UNLOCK_KEY_1) begin
                  s_nxt.unl = UNL_KEY1;
               end else if ((wbyte == UNLOCK_KEY_2) && (s_r.unl == UNL_KEY1)) begin
                  s_nxt.unl = UNL_ARMED;
               end else begin
                  s_nxt.unl = UNL_IDLE;
               end
            end
            default: begin
            end
         endcase
      end

      // Address phase; read data is taken from the post-write state so back-to-back
      // write then read of one register returns the new value with no wait state
      s_nxt.ph_valid = hsel && hready && htrans[1];
      s_nxt.ph_write = hwrite;
      s_nxt.ph_addr = haddr[OFS_W-1:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
         s_nxt.hrdata = {24'h000000, reg_read(haddr[OFS_W-1:0], s_nxt)};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // Write latches
   // ----------------------------------------
   // low five bits pick latch
   assign latch_load = (s_r.seq == SEQ_LATCH);
   assign latch_blank = ((s_r.seq == SEQ_PROG) || (s_r.seq == SEQ_ERASE)) && flash_op_done;

   write_latch_row #(
      .WORDS(LATCH_WORDS),
      .WIDTH(DATA_W),
      .IDX_W(LAT_IDX_W)
   ) u_latches (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(latch_load),
      .load_idx(s_r.adr_lo[LAT_IDX_W-1:0]),
      .load_data({s_r.dat_hi, s_r.dat_lo}),
      .blank(latch_blank),
      .row_data(flash_row_data)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_r.hrdata;
   assign flash_addr = cur_addr;
   assign flash_cfg_sel = s_r.cfg_sel;
   assign flash_rd_en = (s_r.seq == SEQ_READ);
   assign flash_row = cur_addr[ADDR_W-1:LAT_IDX_W];
   assign flash_prog_req = (s_r.seq == SEQ_PROG);
   assign flash_erase_req = (s_r.seq == SEQ_ERASE);
   assign cpu_stall = s_r.wr;

endmodule // self_program_flash_control

// >>> bench/self_program_flash_control_properties.sv
// Port-level assertions for the flash self-programming sequencer
`timescale 1ns/1ps
module flash_ctrl_checker import flash_ctrl_pkg::*; (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, active low
   input wire logic [ADDR_W-1:0] flash_addr, // Word address
   input wire logic flash_rd_en, // Read strobe
   input wire logic flash_prog_req, // Program request
   input wire logic flash_erase_req, // Erase request
   input wire logic [ROW_W-1:0] flash_row, // Target row
   input wire logic [LATCH_WORDS*DATA_W-1:0] flash_row_data, // Latch row
   input wire logic flash_op_done, // Completion pulse
   input wire logic cpu_stall // Processor hold
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ------
   // Operation steps
   // ------
   sequence op_busy;
      flash_prog_req || flash_erase_req;
   endsequence
   sequence op_end;
      op_busy ##0 flash_op_done;
   endsequence
   chk_row_select: assert property (flash_row == flash_addr[14:5])
      else $error("row differs from upper address bits");
   chk_read_pulse: assert property (flash_rd_en |=> !flash_rd_en)
      else $error("read strobe longer than one cycle");
   chk_read_alone: assert property (flash_rd_en |-> !flash_prog_req && !flash_erase_req && !cpu_stall)
      else $error("read strobe during write");
   chk_op_single: assert property (!(flash_prog_req && flash_erase_req))
      else $error("program and erase together");
   chk_req_holds: assert property (op_busy ##0 !flash_op_done |=> $stable({flash_prog_req, flash_erase_req}))
      else $error("request changed before completion");
   chk_stall_busy: assert property (op_busy |-> cpu_stall)
      else $error("processor not held during operation");
   chk_end_clears: assert property (op_end |=> !(flash_prog_req || flash_erase_req) && !cpu_stall)
      else $error("operation not ended by completion");
   chk_latch_blank: assert property (op_end |=> flash_row_data == {LATCH_WORDS{LATCH_BLANK}})
      else $error("latches not blank after operation");
   chk_load_first: assert property ($rose(flash_prog_req) |-> $past(cpu_stall))
      else $error("program began without latch load step");
endmodule // flash_ctrl_checker

bind self_program_flash_control flash_ctrl_checker chk_u (.hclk(hclk), .hresetn(hresetn),
   .flash_addr(flash_addr), .flash_rd_en(flash_rd_en), .flash_prog_req(flash_prog_req),
   .flash_erase_req(flash_erase_req), .flash_row(flash_row), .flash_row_data(flash_row_data),
   .flash_op_done(flash_op_done), .cpu_stall(cpu_stall));

// >>> bench/flash_array_model.sv
// Behavioural flash array answering reads, programs and erases
`timescale 1ns/1ps
module flash_array_model import flash_ctrl_pkg::*; #(
   parameter int OP_CYCLES = 20 // Length of a slow operation
) (
   input wire logic hclk, // System clock
   input wire logic [ADDR_W-1:0] flash_addr, // Word address
   input wire logic flash_cfg_sel, // Config space select
   input wire logic flash_rd_en, // Read strobe
   output logic [DATA_W-1:0] flash_rd_data, // Read word
   input wire logic flash_prog_req, // Program request
   input wire logic flash_erase_req, // Erase request
   input wire logic [ROW_W-1:0] flash_row, // Target row
   input wire logic [LATCH_WORDS*DATA_W-1:0] flash_row_data, // Latch row
   output logic flash_op_done // Completion pulse
);
   logic [DATA_W-1:0] mem [0:1023];
   logic [9:0] base;
   int cnt;
   int nops;
   // Upper half stands for config space, filled with a known pattern
   initial begin
      for (int i = 0; i < 1024; i++) mem[i] = (i < 512) ? LATCH_BLANK : i[13:0];
      flash_rd_data = 14'h0000;
      flash_op_done = 1'h0;
      cnt = 0;
      nops = 0;
   end
   assign base = {flash_cfg_sel, flash_row[3:0], 5'h00};
   always @(posedge hclk) begin
      // Outside a read the data line keeps toggling, never a stale word
      flash_rd_data <= flash_rd_en ? mem[{flash_cfg_sel, flash_addr[8:0]}] : ~flash_rd_data;
      flash_op_done <= 1'h0;
      if ((flash_prog_req || flash_erase_req) && !flash_op_done) begin
         cnt <= cnt + 1;
         // Alternate prompt and slow completion
         if (cnt == (nops[0] ? OP_CYCLES : 0)) begin
            cnt <= 0;
            nops <= nops + 1;
            flash_op_done <= 1'h1;
            for (int i = 0; i < LATCH_WORDS; i++)
               mem[base + i] <= flash_erase_req ? LATCH_BLANK : mem[base + i] & flash_row_data[i*DATA_W +: DATA_W];
         end
      end
   end
endmodule // flash_array_model

// >>> bench/self_program_flash_control_tb.sv
// Register-level testbench for the flash self-programming sequencer
`timescale 1ns/1ps
module self_program_flash_control_tb import flash_ctrl_pkg::*;;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, flash_cfg_sel, flash_rd_en;
   logic flash_prog_req, flash_erase_req, flash_op_done, cpu_stall, prog_q, erase_q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [ADDR_W-1:0] flash_addr;
   logic [DATA_W-1:0] flash_rd_data;
   logic [ROW_W-1:0] flash_row;
   logic [LATCH_WORDS*DATA_W-1:0] flash_row_data;
   int mismatches, tests_run, prog_n, erase_n;
   logic [7:0] k1s [3] = '{8'h55, 8'hAA, 8'h55};
   logic [7:0] o2s [3] = '{8'h14, 8'h14, 8'h00};
   logic [7:0] k2s [3] = '{8'hAA, 8'h55, 8'h11};
   logic [7:0] cts [3] = '{8'h02, 8'h06, 8'h06};
   logic [7:0] exs [3] = '{8'h88, 8'h8C, 8'h8C};

   self_program_flash_control #(.DEVICE_REV_ID(14'h2A5C)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_addr(flash_addr),
      .flash_cfg_sel(flash_cfg_sel), .flash_rd_en(flash_rd_en), .flash_rd_data(flash_rd_data),
      .flash_prog_req(flash_prog_req), .flash_erase_req(flash_erase_req), .flash_row(flash_row),
      .flash_row_data(flash_row_data), .flash_op_done(flash_op_done), .cpu_stall(cpu_stall));
   flash_array_model mdl_u (.hclk(hclk), .flash_addr(flash_addr), .flash_cfg_sel(flash_cfg_sel),
      .flash_rd_en(flash_rd_en), .flash_rd_data(flash_rd_data), .flash_prog_req(flash_prog_req),
      .flash_erase_req(flash_erase_req), .flash_row(flash_row), .flash_row_data(flash_row_data),
      .flash_op_done(flash_op_done));

   initial begin
      hclk = 1'h0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      prog_q <= flash_prog_req;
      erase_q <= flash_erase_req;
      if (flash_prog_req && !prog_q) prog_n++;
      if (flash_erase_req && !erase_q) erase_n++;
   end
   // ------
   // Bus access and compare
   // ------
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'h1;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rdv = hrdata;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         mismatches++;
      end
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
      bus(1'h0, a, 8'h00);
      cmp(n, {24'h000000, e}, rdv);
      cmp("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic wd(input logic [13:0] v);
      bus(1'h1, OFS_DATA_LOW, v[7:0]);
      bus(1'h1, OFS_DATA_HIGH, {2'h0, v[13:8]});
   endtask
   task automatic rw(input string n, input logic [13:0] e);
      rd(n, OFS_DATA_LOW, e[7:0]);
      rd(n, OFS_DATA_HIGH, {2'h0, e[13:8]});
   endtask
   // Address, key-register write, second write to offset o2, control write, then wait for idle
   task automatic op(input logic [14:0] ad, input logic [7:0] k1, o2, k2, ctl);
      int n;
      bus(1'h1, OFS_ADDR_HIGH, {1'h0, ad[14:8]});
      bus(1'h1, OFS_ADDR_LOW, ad[7:0]);
      bus(1'h1, OFS_UNLOCK, k1);
      bus(1'h1, o2, k2);
      bus(1'h1, OFS_CONTROL, ctl);
      n = 0;
      repeat (4) @(posedge hclk);
      while (cpu_stall !== 1'h0 && n < 200) begin
         @(posedge hclk);
         n++;
      end
   endtask
   task automatic end_of_test;
      $display("counts: tests_run %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      end_of_test();
   end
   initial begin
      hresetn = 1'h0;
      hsel = 1'h0;
      hwrite = 1'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      rd("addr_high", OFS_ADDR_HIGH, 8'h80);
      rd("control", OFS_CONTROL, 8'h80);
      rd("addr_low", OFS_ADDR_LOW, 8'h00);
      rd("unlock", OFS_UNLOCK, 8'h00);
      rd("unmapped", 8'h18, 8'h00);
      bus(1'h1, OFS_DATA_HIGH, 8'hFF);
      rd("data_high", OFS_DATA_HIGH, 8'h3F);
      bus(1'h1, OFS_ADDR_HIGH, 8'h2A);
      rd("addr_high", OFS_ADDR_HIGH, 8'hAA);
      $display("test registers done");
      wd(14'h1234);
      op(15'h0021, UNLOCK_KEY_1, OFS_UNLOCK, UNLOCK_KEY_2, 8'h26);
      cmp("prog_n", 32'h0, prog_n);
      rd("control", OFS_CONTROL, 8'hA4);
      wd(14'h0BCD);
      op(15'h0022, UNLOCK_KEY_1, OFS_UNLOCK, UNLOCK_KEY_2, 8'h06);
      cmp("prog_n", 32'h1, prog_n);
      rd("control", OFS_CONTROL, 8'h84);
      op(15'h0021, 8'h00, OFS_UNLOCK, 8'h00, 8'h05);
      rw("word_a", 14'h1234);
      op(15'h0022, 8'h00, OFS_UNLOCK, 8'h00, 8'h05);
      rw("word_b", 14'h0BCD);
      op(15'h0023, 8'h00, OFS_UNLOCK, 8'h00, 8'h05);
      rw("word_c", LATCH_BLANK);
      $display("test program done");
      for (int i = 0; i < 3; i++) begin
         op(15'h0021, k1s[i], o2s[i], k2s[i], cts[i]);
         cmp("prog_n", 32'h1, prog_n);
         rd("control", OFS_CONTROL, exs[i]);
      end
      $display("test refusals done");
      op(15'h0021, UNLOCK_KEY_1, OFS_UNLOCK, UNLOCK_KEY_2, 8'h36);
      cmp("erase_n", 32'h1, erase_n);
      rd("control", OFS_CONTROL, 8'hA4);
      op(15'h0021, 8'h00, OFS_UNLOCK, 8'h00, 8'h05);
      rw("erased", LATCH_BLANK);
      $display("test erase done");
      op(15'h0006, 8'h00, OFS_UNLOCK, 8'h00, 8'h41);
      rw("dev_id", 14'h2A5C);
      op(15'h0001, 8'h00, OFS_UNLOCK, 8'h00, 8'h41);
      rw("user_id", 14'h0201);
      op(15'h0005, 8'h00, OFS_UNLOCK, 8'h00, 8'h41);
      rw("cfg_gap", 14'h0000);
      wd(14'h0F3D);
      op(15'h0007, UNLOCK_KEY_1, OFS_UNLOCK, UNLOCK_KEY_2, 8'h46);
      cmp("prog_n", 32'h1, prog_n);
      op(15'h0002, UNLOCK_KEY_1, OFS_UNLOCK, UNLOCK_KEY_2, 8'h46);
      cmp("prog_n", 32'h2, prog_n);
      op(15'h0002, 8'h00, OFS_UNLOCK, 8'h00, 8'h41);
      rw("uid_prog", 14'h0F3D & 14'h0202);
      $display("test config done");
      end_of_test();
   end
endmodule // self_program_flash_control_tb
